// [eos_enable_seq.sv]
// Twelve open-drain enable outputs driven by sequencer or register bits.
`timescale 1ns/1ps
`include "eos_regs.svh"

module eos_enable_seq
  import eos_pkg::*;
#(
  parameter int unsigned STEP_UNIT_CYCLES =
    `EOS_STEP_UNIT_US * `EOS_CLK_MHZ
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire eos_req_t    reg_req_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire eos_otp_t    otp_cfg_in,
  input  wire logic [3:0]  type_on_req_in,
  input  wire logic [11:0] switch_enable_output_in,
  output logic      [11:0] switch_enable_output_out,
  output logic      [11:0] switch_enable_output_oe_out,
  output logic      [3:0]  seq_busy_out
);

  localparam logic [7:0] CTL_ADR [12] = '{
    `EOS_ENABLE_OUT0_CONTROL_ADR, `EOS_ENABLE_OUT1_CONTROL_ADR, `EOS_ENABLE_OUT2_CONTROL_ADR,
    `EOS_ENABLE_OUT3_CONTROL_ADR, `EOS_ENABLE_OUT4_CONTROL_ADR, `EOS_ENABLE_OUT5_CONTROL_ADR,
    `EOS_ENABLE_OUT6_CONTROL_ADR, `EOS_ENABLE_OUT7_CONTROL_ADR, `EOS_ENABLE_OUT8_CONTROL_ADR,
    `EOS_ENABLE_OUT9_CONTROL_ADR, `EOS_ENABLE_OUT10_CONTROL_ADR, `EOS_ENABLE_OUT11_CONTROL_ADR};
  localparam logic [7:0] SEQ_ADR [12] = '{
    `EOS_EN0_SEQ_ADR, `EOS_EN1_SEQ_ADR, `EOS_EN2_SEQ_ADR,
    `EOS_EN3_SEQ_ADR, `EOS_EN4_SEQ_ADR, `EOS_EN5_SEQ_ADR,
    `EOS_EN6_SEQ_ADR, `EOS_EN7_SEQ_ADR, `EOS_EN8_SEQ_ADR,
    `EOS_EN9_SEQ_ADR, `EOS_EN10_SEQ_ADR, `EOS_EN11_SEQ_ADR};
  localparam logic [7:0] TIM_ADR [4] = '{
    `EOS_TIM_A_ADR, `EOS_TIM_U_ADR, `EOS_TIM_S_ADR, `EOS_TIM_SX_ADR};
  localparam logic [39:0] DLY_TABLE = `EOS_DLY_UNITS;

  eos_state_t s_reg;
  eos_state_t s_next;

  logic [11:0]      pol_v;
  logic [11:0]      sel_v;
  logic [11:0]      man_v;
  logic [11:0]      src_v;
  logic [3:0][23:0] tgt_v;
  logic [3:0][23:0] on_tgt_v;
  logic [3:0][23:0] off_tgt_v;

  // Step delay in clock cycles for one three-bit timing code.
  // delay code table
  function automatic logic [23:0] step_cycles(input logic [2:0] code);
    logic [4:0] units;
    units = DLY_TABLE[code*5 +: 5];
    return 24'(32'(units) * STEP_UNIT_CYCLES);
  endfunction

  // Per-output control fields and the source that requests on.
  for (genvar i = 0; i < 12; i++) begin : g_out
    assign pol_v[i] = s_reg.ctl[i][`EOS_CTL_POL_BIT];
    assign sel_v[i] = s_reg.ctl[i][`EOS_CTL_SEL_BIT];
    assign man_v[i] = s_reg.ctl[i][`EOS_CTL_MAN_BIT];
    assign src_v[i] = sel_v[i] ? man_v[i] : s_reg.seq_on[i];
  end

  // Per-type step delays for each direction.
  for (genvar t = 0; t < 4; t++) begin : g_type
    assign on_tgt_v[t]  = step_cycles(s_reg.tim[t][2:0]);
    assign off_tgt_v[t] = step_cycles(s_reg.tim[t][5:3]);
    assign tgt_v[t] = s_reg.dir[t] ? on_tgt_v[t] : off_tgt_v[t];
  end

  // Next-state logic: factory load, register port, sequencers, pins.
  always_comb begin
    logic [7:0] rd_val;
    rd_val = 8'h00;
    s_next = s_reg;

    // Register read mux; reserved bits read as zero.
    for (int i = 0; i < 12; i++) begin
      if (reg_req_in.addr == CTL_ADR[i]) begin
        rd_val = {5'b0_0000, s_reg.ctl[i]};
      end
      if (reg_req_in.addr == SEQ_ADR[i]) begin
        rd_val = {2'b00, s_reg.grp[i]};
      end
    end
    for (int t = 0; t < 4; t++) begin
      if (reg_req_in.addr == TIM_ADR[t]) begin
        rd_val = {1'b0, s_reg.tim[t][5:3], 1'b0, s_reg.tim[t][2:0]};
      end
    end
    if (reg_req_in.rd) begin
      s_next.rdata = rd_val;
    end

    if (!s_reg.loaded) begin
      // First cycle after reset: take factory values.
      s_next.loaded = 1'b1;
      for (int i = 0; i < 5; i++) begin
        s_next.ctl[i][`EOS_CTL_POL_BIT] = otp_cfg_in.pol[i];
      end
      s_next.grp = otp_cfg_in.grp;
      for (int t = 0; t < 4; t++) begin
        s_next.tim[t] = {otp_cfg_in.tim[t], otp_cfg_in.tim[t]};
      end
    end else if (reg_req_in.wr) begin
      // Register writes; only documented bits are stored.
      for (int i = 0; i < 12; i++) begin
        if (reg_req_in.addr == CTL_ADR[i]) begin
          s_next.ctl[i] = reg_req_in.wdata[2:0];
        end
        if (reg_req_in.addr == SEQ_ADR[i]) begin
          s_next.grp[i] = reg_req_in.wdata[5:0];
        end
      end
      for (int t = 0; t < 4; t++) begin
        if (reg_req_in.addr == TIM_ADR[t]) begin
          s_next.tim[t] = {reg_req_in.wdata[6:4], reg_req_in.wdata[2:0]};
        end
      end
    end

    // One sequencer per rail type.
    for (int t = 0; t < 4; t++) begin
      case (s_reg.st[t])
        SEQ_IDLE: begin
          s_next.st[t] = SEQ_IDLE;
        end
        SEQ_APPLY: begin
          for (int i = 0; i < 12; i++) begin
            if (s_reg.grp[i][5:4] == 2'(t) &&
                s_reg.grp[i][3:0] == s_reg.idx[t] &&
                s_reg.grp[i][3:0] != `EOS_GRP_DISABLE) begin
              s_next.seq_on[i] = s_reg.dir[t];
            end
          end
          if (s_reg.idx[t] == (s_reg.dir[t] ? `EOS_GRP_LAST : 4'h0)) begin
            s_next.st[t] = SEQ_IDLE;
          end else begin
            s_next.st[t]  = SEQ_WAIT;
            s_next.cnt[t] = `EOS_WAIT_START;
          end
        end
        SEQ_WAIT: begin
          if (s_reg.cnt[t] >= tgt_v[t]) begin
            s_next.idx[t] = s_reg.dir[t] ? s_reg.idx[t] + 4'h1
                                         : s_reg.idx[t] - 4'h1;
            s_next.st[t]  = SEQ_APPLY;
          end else begin
            s_next.cnt[t] = s_reg.cnt[t] + 24'h00_0001;
          end
        end
        default: begin
          s_next.st[t] = SEQ_IDLE;
        end
      endcase
      // A change of the type request restarts that type's sequence.
      if (s_reg.loaded) begin
        s_next.req_q[t] = type_on_req_in[t];
        if (type_on_req_in[t] != s_reg.req_q[t]) begin
          s_next.dir[t] = type_on_req_in[t];
          s_next.idx[t] = type_on_req_in[t] ? 4'h0 : `EOS_GRP_LAST;
          s_next.st[t]  = SEQ_APPLY;
        end
      end
      // Busy is a flop of its own so the output needs no decode.
      s_next.busy[t] = s_next.st[t] != SEQ_IDLE;
    end

    // Pin driver: pull low when the request differs from the polarity bit.
    // on pulls low by default
    s_next.oe  = src_v ^ pol_v;
    s_next.drv = 12'h000;
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
      for (int t = 0; t < 4; t++) begin
        s_reg.st[t] <= SEQ_IDLE;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from state flip-flops.
  assign reg_rdata_out               = s_reg.rdata;
  assign switch_enable_output_out    = s_reg.drv;
  assign switch_enable_output_oe_out = s_reg.oe;
  assign seq_busy_out                = s_reg.busy;

  // Pin drive level never goes high.
  a_pin_open_drain: assert property (
    @(posedge clk_in) disable iff (srst_in)
    switch_enable_output_out == 12'h000)
    else $error("enable pin driven high");

  // Factory polarity appears in the first loaded cycle.
  a_otp_pol_load: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !s_reg.loaded ##1 s_reg.loaded |->
      pol_v[4:0] == $past(otp_cfg_in.pol) && pol_v[11:5] == 7'h00)
    else $error("factory polarity not loaded");

  // Control write lands in the next cycle.
  a_ctl_write: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.loaded && reg_req_in.wr && reg_req_in.addr == CTL_ADR[3]
    |=> s_reg.ctl[3] == $past(reg_req_in.wdata[2:0]))
    else $error("control write lost");

  // Pin follows selected source and polarity one cycle later.
  a_pin_follow: assert property (
    @(posedge clk_in) disable iff (srst_in)
    1'b1 |=> switch_enable_output_oe_out ==
      ($past(src_v) ^ $past(pol_v)))
    else $error("enable pin does not follow source");

  // Disabled group is never switched by the sequencer.
  a_grp_disabled: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.grp[0][3:0] == `EOS_GRP_DISABLE |=>
      s_reg.seq_on[0] == $past(s_reg.seq_on[0]))
    else $error("disabled output switched");

  // A new on request starts at group zero, turning on.
  a_seq_first_idx: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.loaded && type_on_req_in[0] && !s_reg.req_q[0] |=>
      s_reg.st[0] == SEQ_APPLY && s_reg.idx[0] == 4'h0 && s_reg.dir[0])
    else $error("on sequence did not start at group zero");

  // Waiting holds until the step delay is reached.
  a_off_wait_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[1] == SEQ_WAIT && !s_reg.dir[1] &&
    s_reg.cnt[1] < off_tgt_v[1] && type_on_req_in[1] == s_reg.req_q[1]
    |=> s_reg.st[1] == SEQ_WAIT)
    else $error("turn-off step ended early");

  // Turn-on step ends exactly at its delay and moves up one group.
  a_on_step_end: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[2] == SEQ_WAIT && s_reg.dir[2] &&
    s_reg.cnt[2] >= on_tgt_v[2] && type_on_req_in[2] == s_reg.req_q[2]
    |=> s_reg.st[2] == SEQ_APPLY &&
      s_reg.idx[2] == $past(s_reg.idx[2]) + 4'h1)
    else $error("turn-on step did not advance");

  // Factory load makes both step fields equal.
  a_otp_equal_steps: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !s_reg.loaded |=> s_reg.tim[3][5:3] == s_reg.tim[3][2:0])
    else $error("factory step fields differ");

  // A request change makes the sequencer busy in the next cycle.
  a_busy_start: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.loaded && type_on_req_in[1] != s_reg.req_q[1]
    |=> seq_busy_out[1])
    else $error("sequencer did not report busy");

  // Read data holds while no read is taken.
  a_rdata_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !reg_req_in.rd |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  // Reserved control bits read back as zero.
  a_ctl_reserved_zero: assert property (
    @(posedge clk_in) disable iff (srst_in)
    reg_req_in.rd && reg_req_in.addr == CTL_ADR[7]
    |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved control bits not zero");

  // Reserved timing bits read back as zero.
  a_tim_reserved_zero: assert property (
    @(posedge clk_in) disable iff (srst_in)
    reg_req_in.rd && reg_req_in.addr == TIM_ADR[0]
    |=> !reg_rdata_out[7] && !reg_rdata_out[3])
    else $error("reserved timing bits not zero");

  // A new off request starts at the last group, turning off.
  a_off_first_idx: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.loaded && !type_on_req_in[0] && s_reg.req_q[0] |=>
      s_reg.st[0] == SEQ_APPLY && s_reg.idx[0] == `EOS_GRP_LAST &&
      !s_reg.dir[0])
    else $error("off sequence did not start at last group");

  // An index that is not the last is followed by a fresh wait.
  a_apply_to_wait: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[0] == SEQ_APPLY && type_on_req_in[0] == s_reg.req_q[0] &&
    s_reg.idx[0] != (s_reg.dir[0] ? `EOS_GRP_LAST : 4'h0)
    |=> s_reg.st[0] == SEQ_WAIT && s_reg.cnt[0] == `EOS_WAIT_START)
    else $error("step wait did not start");

  // The last index ends the sequence and clears busy.
  a_last_idx_idle: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[3] == SEQ_APPLY && type_on_req_in[3] == s_reg.req_q[3] &&
    s_reg.idx[3] == (s_reg.dir[3] ? `EOS_GRP_LAST : 4'h0)
    |=> s_reg.st[3] == SEQ_IDLE && !seq_busy_out[3])
    else $error("sequence did not end after last group");

  // An output whose type and group match the index takes the direction.
  a_seq_switch_out: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[1] == SEQ_APPLY && s_reg.grp[1] == {2'b01, s_reg.idx[1]}
    |=> s_reg.seq_on[1] == $past(s_reg.dir[1]))
    else $error("matching output not switched");

  // Sequencers of other types leave a type A output alone.
  a_type_guard: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.grp[4][5:4] == 2'b00 && s_reg.st[0] != SEQ_APPLY
    |=> s_reg.seq_on[4] == $past(s_reg.seq_on[4]))
    else $error("output switched by another rail type");

  // With register source the pin follows bit 0 and polarity.
  a_manual_pin: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.ctl[6][`EOS_CTL_SEL_BIT] |=> switch_enable_output_oe_out[6] ==
      ($past(s_reg.ctl[6][`EOS_CTL_MAN_BIT]) ^
       $past(s_reg.ctl[6][`EOS_CTL_POL_BIT])))
    else $error("register source does not drive pin");

  // Turn-off step ends at its delay and moves down one group.
  a_off_step_end: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_reg.st[0] == SEQ_WAIT && !s_reg.dir[0] &&
    s_reg.cnt[0] >= off_tgt_v[0] && type_on_req_in[0] == s_reg.req_q[0]
    |=> s_reg.st[0] == SEQ_APPLY &&
      s_reg.idx[0] == $past(s_reg.idx[0]) - 4'h1)
    else $error("turn-off step did not advance");

endmodule // eos_enable_seq

// [eos_pkg.sv]
// Types shared by the enable output sequencer.
package eos_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_APPLY = 3'b010,
    SEQ_WAIT  = 3'b100
  } eos_seq_t;

  // Factory programmed values sampled after reset.
  typedef struct packed {
    logic [4:0]       pol;
    logic [11:0][5:0] grp;
    logic [3:0][2:0]  tim;
  } eos_otp_t;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eos_req_t;

  // All block state.
  typedef struct packed {
    logic [11:0][2:0] ctl;
    logic [11:0][5:0] grp;
    logic [3:0][5:0]  tim;
    logic [11:0]      seq_on;
    logic [11:0]      oe;
    logic [11:0]      drv;
    logic [7:0]       rdata;
    logic             loaded;
    logic [3:0]       req_q;
    logic [3:0]       busy;
    logic [3:0]       dir;
    logic [3:0][3:0]  idx;
    logic [3:0][23:0] cnt;
    eos_seq_t [3:0]   st;
  } eos_state_t;

endpackage

// [eos_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef EOS_REGS_SVH
`define EOS_REGS_SVH

// Enable control registers.
`define EOS_ENABLE_OUT0_CONTROL_ADR 8'h56
`define EOS_ENABLE_OUT1_CONTROL_ADR 8'h57
`define EOS_ENABLE_OUT2_CONTROL_ADR 8'h5B
`define EOS_ENABLE_OUT3_CONTROL_ADR 8'h5C
`define EOS_ENABLE_OUT4_CONTROL_ADR 8'h5D
`define EOS_ENABLE_OUT5_CONTROL_ADR 8'h69
`define EOS_ENABLE_OUT6_CONTROL_ADR 8'h68
`define EOS_ENABLE_OUT7_CONTROL_ADR 8'h64
`define EOS_ENABLE_OUT8_CONTROL_ADR 8'h62
`define EOS_ENABLE_OUT9_CONTROL_ADR 8'h6B
`define EOS_ENABLE_OUT10_CONTROL_ADR 8'h6C
`define EOS_ENABLE_OUT11_CONTROL_ADR 8'h6D

// Enable sequencing registers.
`define EOS_EN0_SEQ_ADR 8'hF4
`define EOS_EN1_SEQ_ADR 8'hF5
`define EOS_EN2_SEQ_ADR 8'hF6
`define EOS_EN3_SEQ_ADR 8'hF7
`define EOS_EN4_SEQ_ADR 8'hF8
`define EOS_EN5_SEQ_ADR 8'hF9
`define EOS_EN6_SEQ_ADR 8'hFA
`define EOS_EN7_SEQ_ADR 8'hFB
`define EOS_EN8_SEQ_ADR 8'hFC
`define EOS_EN9_SEQ_ADR 8'hFD
`define EOS_EN10_SEQ_ADR 8'hFE
`define EOS_EN11_SEQ_ADR 8'h7D

// Group timing registers, one per rail type A, U, S, SX.
`define EOS_TIM_A_ADR 8'hC3
`define EOS_TIM_U_ADR 8'hC4
`define EOS_TIM_S_ADR 8'hD3
`define EOS_TIM_SX_ADR 8'hD4

// Field positions.
`define EOS_CTL_MAN_BIT 0
`define EOS_CTL_SEL_BIT 1
`define EOS_CTL_POL_BIT 2
`define EOS_GRP_DISABLE 4'hF
`define EOS_GRP_LAST 4'hE
`define EOS_CTL_RST 8'h00

// Step delays in quarter-millisecond units, codes 0 to 7.
`define EOS_STEP_UNIT_US 250
`define EOS_CLK_MHZ 25
`define EOS_DLY_UNITS {5'd20, 5'd12, 5'd10, 5'd8, 5'd6, 5'd4, 5'd2, 5'd1}
`define EOS_WAIT_START 24'h00_0002

`endif

// [eos_switch_model.sv]
// Pull-up and switch model hanging on the twelve enable pins.
`timescale 1ns/1ps
module eos_switch_model (
  input  wire logic [11:0] drv_in,
  input  wire logic [11:0] oe_in,
  output logic      [11:0] pin_out
);
  // A released pin floats up to the external pull-up level.
  // open-drain pull-up.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pin_out[i] = oe_in[i] ? drv_in[i] : 1'b1;
    end
  end
endmodule // eos_switch_model

// [tb_eos_enable_seq.sv]
// Self-checking bench for the enable output sequencer.
`timescale 1ns/1ps
`include "eos_regs.svh"
module tb_eos_enable_seq
  import eos_pkg::*;
  ;
  localparam int SU = 2;
  logic        clk_in;
  logic        srst_in;
  eos_req_t    req;
  eos_otp_t    otp;
  logic [3:0]  type_req;
  logic [7:0]  rdata;
  logic [11:0] pin;
  logic [11:0] drv;
  logic [11:0] oe;
  logic [3:0]  busy;
  logic [1:0]  ty[12];
  logic [3:0]  g[12];
  int          fails;
  int          compares;
  int          t_chg[12];
  logic [7:0]  ctl_adr[12] = '{`EOS_ENABLE_OUT0_CONTROL_ADR, `EOS_ENABLE_OUT1_CONTROL_ADR,
    `EOS_ENABLE_OUT2_CONTROL_ADR, `EOS_ENABLE_OUT3_CONTROL_ADR, `EOS_ENABLE_OUT4_CONTROL_ADR, `EOS_ENABLE_OUT5_CONTROL_ADR,
    `EOS_ENABLE_OUT6_CONTROL_ADR, `EOS_ENABLE_OUT7_CONTROL_ADR, `EOS_ENABLE_OUT8_CONTROL_ADR, `EOS_ENABLE_OUT9_CONTROL_ADR,
    `EOS_ENABLE_OUT10_CONTROL_ADR, `EOS_ENABLE_OUT11_CONTROL_ADR};
  logic [7:0]  seq_adr[12] = '{`EOS_EN0_SEQ_ADR, `EOS_EN1_SEQ_ADR,
    `EOS_EN2_SEQ_ADR, `EOS_EN3_SEQ_ADR, `EOS_EN4_SEQ_ADR, `EOS_EN5_SEQ_ADR,
    `EOS_EN6_SEQ_ADR, `EOS_EN7_SEQ_ADR, `EOS_EN8_SEQ_ADR, `EOS_EN9_SEQ_ADR,
    `EOS_EN10_SEQ_ADR, `EOS_EN11_SEQ_ADR};
  logic [7:0]  tim_adr[4] = '{`EOS_TIM_A_ADR, `EOS_TIM_U_ADR,
    `EOS_TIM_S_ADR, `EOS_TIM_SX_ADR};

  eos_enable_seq #(.STEP_UNIT_CYCLES(SU)) DUT (
    .clk_in(clk_in), .srst_in(srst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .otp_cfg_in(otp), .type_on_req_in(type_req),
    .switch_enable_output_in(pin), .switch_enable_output_out(drv),
    .switch_enable_output_oe_out(oe), .seq_busy_out(busy));

  eos_switch_model PART (.drv_in(drv), .oe_in(oe), .pin_out(pin));

  // Clock at 25 MHz.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [11:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Byte write, entered just after a clock edge.
  // An idle edge follows so that the next call never re-raises the strobe
  // in the same time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge clk_in);
    #1 req.wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  // Byte read; data is registered on the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.addr = a;
    req.rd = 1'b1;
    @(posedge clk_in);
    #1 req.rd = 1'b0;
    d = rdata;
    @(posedge clk_in);
    #1;
  endtask

  // Step delay in clock cycles for a three-bit delay code.
  function automatic int steps(input logic [2:0] c);
    int u[8] = '{1, 2, 4, 6, 8, 10, 12, 20};
    return u[c] * SU;
  endfunction

  // Runs one sequence of type t and checks each pin's switching cycle.
  task automatic run(input int t, input logic on, input int st);
    logic [11:0] prev;
    logic        seen;
    int          n;
    int          k;
    int          quiet;
    prev = oe;
    seen = 1'b0;
    n = 0;
    quiet = 0;
    for (int i = 0; i < 12; i++) t_chg[i] = -1;
    type_req[t] = on;
    // Stay one cycle past busy falling: the last group's pin moves then.
    while (n < 15 * st + 20 && quiet < 2) begin
      @(posedge clk_in);
      #1 n++;
      if (busy[t] === 1'b1) seen = 1'b1;
      quiet = (n > 3 && busy[t] === 1'b0) ? quiet + 1 : 0;
      for (int i = 0; i < 12; i++) begin
        if (t_chg[i] < 0 && oe[i] !== prev[i]) t_chg[i] = n;
      end
    end
    chk({11'h0, seen}, 12'h001, "busy seen");
    chk({11'h0, busy[t]}, 12'h000, "busy end");
    for (int i = 0; i < 12; i++) begin
      k = on ? int'(g[i]) : 14 - int'(g[i]);
      if (ty[i] == 2'(t) && g[i] != 4'hF) begin
        chk(12'(t_chg[i]), 12'(3 + k * st), "group cycle");
        chk({11'h0, oe[i]}, {11'h0, on}, "seq level");
      end else begin
        chk(12'(t_chg[i]), 12'hFFF, "untouched pin");
      end
    end
    $display("test sequence type %0d dir %0d done", t, on);
  endtask

  // Closing report and verdict.
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    #2_000_000;
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end

  // Main sequence.
  initial begin
    logic [7:0] d;
    logic [2:0] v;
    logic [2:0] c_on;
    logic [2:0] c_off;
    int         i;
    logic       p;
    void'($urandom(4));
    fails = 0;
    compares = 0;
    req = '0;
    type_req = 4'h0;
    srst_in = 1'b1;
    otp.pol = 5'($urandom);
    for (int j = 0; j < 12; j++) otp.grp[j] = 6'($urandom);
    for (int j = 0; j < 4; j++) otp.tim[j] = 3'($urandom);
    repeat (5) @(posedge clk_in);
    #1 srst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk(oe, {7'h0, otp.pol}, "reset pins");
    chk(drv, 12'h000, "drive value");
    for (int j = 0; j < 12; j++) begin
      rd(ctl_adr[j], d);
      chk({4'h0, d}, {9'h000, (j < 5) & otp.pol[j], 2'b00}, "ctl");
      rd(seq_adr[j], d);
      chk({4'h0, d}, {6'h00, otp.grp[j]}, "seq reset");
    end
    for (int t = 0; t < 4; t++) begin
      rd(tim_adr[t], d);
      chk({4'h0, d}, {5'h00, otp.tim[t], 1'b0, otp.tim[t]},
        "tim reset");
    end
    rd(8'h00, d);
    chk({4'h0, d}, 12'h000, "unmapped");
    $display("test reset values done");
    for (int j = 0; j < 40; j++) begin
      // First pass is a fixed corner: register source, off, active high.
      i = (j == 0) ? 6 : int'($urandom % 12);
      v = (j == 0) ? 3'b110 : 3'($urandom);
      wr(ctl_adr[i], {5'h1F, v});
      repeat (2) @(posedge clk_in);
      #1 rd(ctl_adr[i], d);
      p = ~((v[1] & v[0]) ^ v[2]);
      chk({4'h0, d}, {9'h000, v}, "ctl readback");
      chk({11'h000, pin[i]}, {11'h000, p}, "manual pin");
    end
    $display("test manual control done");
    for (int j = 0; j < 12; j++) begin
      ty[j] = 2'(j % 4);
      g[j] = (j == 0) ? 4'hF : (j == 1) ? 4'h0 : (j == 2) ? 4'hE
        : 4'($urandom);
      wr(ctl_adr[j], 8'h00);
      wr(seq_adr[j], {2'b00, ty[j], g[j]});
    end
    repeat (2) @(posedge clk_in);
    #1;
    for (int t = 0; t < 4; t++) begin
      c_on = 3'($urandom);
      c_off = 3'($urandom);
      wr(tim_adr[t], {1'b1, c_off, 1'b1, c_on});
      rd(tim_adr[t], d);
      chk({4'h0, d}, {5'h00, c_off, 1'b0, c_on}, "tim rb");
      run(t, 1'b1, steps(c_on));
      run(t, 1'b0, steps(c_off));
    end
    test_done();
  end
endmodule // tb_eos_enable_seq
